//--- hdl/flash_pkg.sv
// Functional notes
// - control register hidden until unlock sequence
// - loading control register never starts operation
// - program mode shows supply-ready and supply-fail bits
// - supply-ready reads one when high voltage correct
// - programming needs write-enable bit set
// - default pulse 6.4 us at 20 MHz
// - width bit selects double word or word
// - program mode needs write-mode confirmation bit
// - erase applies to whole block at once
// - busy flag high while pulse runs
// - data write starts programming, even then odd
// - supply-fail set when voltage drops mid-operation
// - clearing write enable stops all activity
package flash_pkg;

  localparam int AXI_AW = 8;
  localparam int CNT_W  = 20;
  localparam int ARR_AW = 6;
  localparam int BLK_W  = 2;
  localparam int IRQ_W  = 2;

  localparam logic [AXI_AW-1:0] OFS_UNLOCK   = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_FCR      = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_ERASE    = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_PADDR    = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_PDATA    = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_RADDR    = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_RDATA    = 8'h18;
  localparam logic [AXI_AW-1:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [AXI_AW-1:0] OFS_IRQ_MASK = 8'h20;

  localparam logic [15:0] UNLOCK_KEY_A = 16'h00a5;
  localparam logic [15:0] UNLOCK_KEY_B = 16'h005a;
  localparam logic [15:0] ERASE_KEY    = 16'h00e5;

  // flash_control_reg layout
  localparam int FCR_FWE       = 0;
  localparam int FCR_FEE       = 1;
  localparam int FCR_PWS0      = 2;
  localparam int FCR_PWS1      = 3;
  localparam int FCR_WDWW      = 4;
  localparam int FCR_FWMSET    = 5;
  localparam int FCR_BLK_LO    = 6;
  localparam int FCR_SUPPLY_OK = 8;
  localparam int FCR_FAIL      = 9;
  localparam int FCR_BUSY      = 10;
  localparam logic [7:0] FCR_RESET = 8'h00;

  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [15:0] ERASED_WORD = 16'hffff;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int PROG_PULSE_NS   = 6400;
  localparam int MID_PULSE_NS    = 12800;
  localparam int ERASE_PULSE_NS  = 1640000;
  localparam int LONG_PULSE_NS   = 3280000;
  localparam logic [CNT_W-1:0] PROG_PULSE_CYC =
    CNT_W'((PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MID_PULSE_CYC =
    CNT_W'((MID_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ERASE_PULSE_CYC =
    CNT_W'((ERASE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] LONG_PULSE_CYC =
    CNT_W'((LONG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_PROG  = 3'b010,
    OP_ERASE = 3'b100
  } op_state_t;

endpackage

//--- hdl/flash_array.sv
`timescale 1ns/1ns
`default_nettype none
module flash_array
  import flash_pkg::*;
(
  input  wire logic              aclk,     // clock
  input  wire logic              aresetn,  // sync reset, low
  input  wire logic [ARR_AW-1:0] rd_addr,  // read word address
  output logic      [15:0]       rd_data,  // registered read word
  input  wire logic              wr_en,    // program pulse ends
  input  wire logic              wr_dw,    // also program odd word
  input  wire logic [ARR_AW-1:0] wr_addr,  // word address, even for double word
  input  wire logic [15:0]       wr_lo,    // data for the wr_addr word
  input  wire logic [15:0]       wr_hi,    // odd word data
  input  wire logic              erase_en, // erase pulse ends
  input  wire logic [BLK_W-1:0]  erase_blk // block to erase
);
  localparam int DEPTH = 1 << ARR_AW;
  localparam int BLK_SHIFT = ARR_AW - BLK_W;

  logic [15:0] cell_r [DEPTH];

  // programming only pulls bits to zero, like a real cell
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
      localparam logic [ARR_AW-1:0] ADDR = ARR_AW'(i);
      wire in_blk = (ADDR[ARR_AW-1:BLK_SHIFT] == erase_blk);
      wire hit_lo = wr_en && (ADDR == wr_addr);
      wire hit_hi = wr_en && wr_dw && (ADDR == (wr_addr | ARR_AW'(1)));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cell_r[i] <= ERASED_WORD;
        end else if (erase_en && in_blk) begin
          cell_r[i] <= ERASED_WORD;
        end else if (hit_lo) begin
          cell_r[i] <= cell_r[i] & wr_lo;
        end else if (hit_hi) begin
          cell_r[i] <= cell_r[i] & wr_hi;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= cell_r[rd_addr];
    end
  end
endmodule
`default_nettype wire

//--- hdl/flash_program_control.sv
`timescale 1ns/1ns
`default_nettype none
module flash_program_control
  import flash_pkg::*;
#(
  parameter logic [CNT_W-1:0] ERASE_CYC = ERASE_PULSE_CYC,
  parameter logic [CNT_W-1:0] LONG_CYC  = LONG_PULSE_CYC
)(
  input  wire logic              aclk,      // clock, 20 MHz
  input  wire logic              aresetn,   // sync reset, low
  input  wire logic [AXI_AW-1:0] awaddr,    // write address
  input  wire logic [2:0]        awprot,    // unused protection
  input  wire logic              awvalid,   // write address valid
  output logic                   awready,   // write address ready
  input  wire logic [31:0]       wdata,     // write data
  input  wire logic [3:0]        wstrb,     // byte strobes
  input  wire logic              wvalid,    // write data valid
  output logic                   wready,    // write data ready
  output logic [1:0]             bresp,     // write response
  output logic                   bvalid,    // write response valid
  input  wire logic              bready,    // write response ready
  input  wire logic [AXI_AW-1:0] araddr,    // read address
  input  wire logic [2:0]        arprot,    // unused protection
  input  wire logic              arvalid,   // read address valid
  output logic                   arready,   // read address ready
  output logic [31:0]            rdata,     // read data
  output logic [1:0]             rresp,     // read response
  output logic                   rvalid,    // read data valid
  input  wire logic              rready,    // read data ready
  input  wire logic              vpp_level, // high-voltage good pin, async
  output logic                   irq        // level interrupt
);

  // bus slave state
  logic              aw_held_r;
  logic [AXI_AW-1:0] aw_addr_r;
  logic              w_held_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;

  // block state
  logic              key_seen_r;
  logic              unlocked_r;
  logic [7:0]        fcr_r;
  logic              prog_mode_r;
  logic              supply_fail_r;
  logic              vpp_s1_r;
  logic              vpp_s2_r;
  op_state_t         state_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  op_len_r;
  logic [1:0]        op_sel_r;
  logic              op_dw_r;
  logic [ARR_AW-1:0] paddr_r;
  logic [15:0]       plo_r;
  logic [15:0]       phi_r;
  logic              half_r;
  logic [ARR_AW-1:0] raddr_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [15:0]       mem_q;

  // write decode
  wire wr_fire      = aw_held_r && w_held_r && !bvalid;
  wire wr_hit_unl   = (aw_addr_r == OFS_UNLOCK);
  wire wr_hit_fcr   = (aw_addr_r == OFS_FCR);
  wire wr_hit_erase = (aw_addr_r == OFS_ERASE);
  wire wr_hit_paddr = (aw_addr_r == OFS_PADDR);
  wire wr_hit_pdata = (aw_addr_r == OFS_PDATA);
  wire wr_hit_raddr = (aw_addr_r == OFS_RADDR);
  wire wr_hit_stat  = (aw_addr_r == OFS_IRQ_STAT);
  wire wr_hit_mask  = (aw_addr_r == OFS_IRQ_MASK);
  wire wr_hit_rdat  = (aw_addr_r == OFS_RDATA);
  wire wr_mapped    = wr_hit_unl | wr_hit_fcr | wr_hit_erase | wr_hit_paddr
                    | wr_hit_pdata | wr_hit_raddr | wr_hit_stat | wr_hit_mask
                    | wr_hit_rdat;
  // unstrobed bytes are written as zero
  wire [15:0] w_lo = {w_strb_r[1] ? w_data_r[15:8] : 8'h00,
                      w_strb_r[0] ? w_data_r[7:0] : 8'h00};
  wire [15:0] w_hi = {w_strb_r[3] ? w_data_r[31:24] : 8'h00,
                      w_strb_r[2] ? w_data_r[23:16] : 8'h00};

  wire busy      = (state_r != OP_IDLE);
  wire fcr_wr    = wr_fire && wr_hit_fcr && unlocked_r;
  wire op_abort  = fcr_wr && !w_lo[FCR_FWE];
  wire op_done   = busy && (cnt_r == '0) && !op_abort;
  wire idle_ok   = !busy && prog_mode_r && fcr_r[FCR_FWE];
  wire prog_ok   = idle_ok && !fcr_r[FCR_FEE];
  wire erase_go  = wr_fire && wr_hit_erase && (w_lo == ERASE_KEY)
                 && idle_ok && fcr_r[FCR_FEE];
  wire pdata_wr  = wr_fire && wr_hit_pdata && prog_ok;
  wire dw_first  = pdata_wr && fcr_r[FCR_WDWW] && !half_r;
  wire prog_go   = pdata_wr && !dw_first;
  wire [1:0] sel = {fcr_r[FCR_PWS1], fcr_r[FCR_PWS0]};
  wire [CNT_W-1:0] pulse_len = (sel == 2'b00) ? PROG_PULSE_CYC :
                               (sel == 2'b01) ? MID_PULSE_CYC :
                               (sel == 2'b10) ? ERASE_CYC : LONG_CYC;
  wire fail_set  = busy && !vpp_s2_r;

  // read decode
  wire ar_fire      = arvalid && arready;
  wire rd_hit_unl   = (araddr == OFS_UNLOCK);
  wire rd_hit_fcr   = (araddr == OFS_FCR);
  wire rd_hit_paddr = (araddr == OFS_PADDR);
  wire rd_hit_raddr = (araddr == OFS_RADDR);
  wire rd_hit_rdat  = (araddr == OFS_RDATA);
  wire rd_hit_stat  = (araddr == OFS_IRQ_STAT);
  wire rd_hit_mask  = (araddr == OFS_IRQ_MASK);
  wire rd_mapped    = rd_hit_unl | rd_hit_fcr | rd_hit_paddr | rd_hit_raddr
                    | rd_hit_rdat | rd_hit_stat | rd_hit_mask
                    | (araddr == OFS_ERASE) | (araddr == OFS_PDATA);
  wire [15:0] fcr_view = {5'h00, busy, supply_fail_r & prog_mode_r,
                          vpp_s2_r & prog_mode_r, fcr_r};
  wire [15:0] rd_word =
    (rd_hit_fcr && unlocked_r)    ? fcr_view :
    rd_hit_unl                    ? {15'h0000, unlocked_r} :
    rd_hit_paddr                  ? {{(16-ARR_AW){1'b0}}, paddr_r} :
    rd_hit_raddr                  ? {{(16-ARR_AW){1'b0}}, raddr_r} :
    (rd_hit_rdat && !prog_mode_r) ? mem_q :
    rd_hit_stat                   ? {{(16-IRQ_W){1'b0}}, irq_stat_r} :
    rd_hit_mask                   ? {{(16-IRQ_W){1'b0}}, irq_mask_r} : 16'h0000;

  // sticky events; set wins over the read clear
  wire stat_clr = ar_fire && rd_hit_stat;
  wire [IRQ_W-1:0] stat_set = {fail_set && !supply_fail_r, op_done};
  wire [IRQ_W-1:0] stat_nxt = (stat_clr ? '0 : irq_stat_r) | stat_set;

  // bus write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      awready   <= 1'b0;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      awready <= !aw_held_r && !(awvalid && awready);
      wready  <= !w_held_r && !(wvalid && wready);
      if (awvalid && awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid    <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
      end
    end
  end

  // bus read channel, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (ar_fire) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {16'h0000, rd_word};
      rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

  // high-voltage level from the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vpp_s1_r <= 1'b0;
      vpp_s2_r <= 1'b0;
    end else begin
      vpp_s1_r <= vpp_level;
      vpp_s2_r <= vpp_s1_r;
    end
  end

  // unlock sequence: two keys written back to back to the unlock word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_seen_r <= 1'b0;
      unlocked_r <= 1'b0;
    end else if (op_abort) begin
      key_seen_r <= 1'b0;
      unlocked_r <= 1'b0;
    end else if (wr_fire) begin
      key_seen_r <= wr_hit_unl && (w_lo == UNLOCK_KEY_A);
      if (wr_hit_unl && key_seen_r && (w_lo == UNLOCK_KEY_B)) begin
        unlocked_r <= 1'b1;
      end
    end
  end

  // control register and program mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fcr_r         <= FCR_RESET;
      prog_mode_r   <= 1'b0;
      supply_fail_r <= 1'b0;
    end else begin
      // config changes mid-pulse are ignored; only an abort gets through
      if (fcr_wr && (!busy || op_abort)) begin
        fcr_r       <= w_lo[7:0];
        prog_mode_r <= w_lo[FCR_FWMSET] && w_lo[FCR_FWE];
      end
      if (fail_set) begin
        supply_fail_r <= 1'b1;
      end else if (fcr_wr) begin
        supply_fail_r <= 1'b0;
      end
    end
  end

  // address and data latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      paddr_r <= '0;
      raddr_r <= '0;
      plo_r   <= 16'h0000;
      phi_r   <= 16'h0000;
      half_r  <= 1'b0;
    end else begin
      if (wr_fire && wr_hit_paddr) begin
        paddr_r <= w_lo[ARR_AW-1:0];
      end
      if (wr_fire && wr_hit_raddr) begin
        raddr_r <= w_lo[ARR_AW-1:0];
      end
      if (dw_first) begin
        plo_r  <= w_lo;
        half_r <= 1'b1;
      end else if (prog_go) begin
        if (half_r) begin
          phi_r <= w_lo;
        end else begin
          plo_r <= w_lo;
        end
        half_r <= 1'b0;
      end else if (fcr_wr) begin
        half_r <= 1'b0;
      end
    end
  end

  // pulse sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r  <= OP_IDLE;
      cnt_r    <= '0;
      op_len_r <= '0;
      op_sel_r <= 2'b00;
      op_dw_r  <= 1'b0;
    end else begin
      case (state_r)
        OP_IDLE: begin
          if (prog_go || erase_go) begin
            state_r  <= prog_go ? OP_PROG : OP_ERASE;
            cnt_r    <= pulse_len - CNT_W'(1);
            op_len_r <= pulse_len;
            op_sel_r <= sel;
            op_dw_r  <= prog_go && half_r;
          end
        end
        OP_PROG, OP_ERASE: begin
          if (op_abort || op_done) begin
            state_r <= OP_IDLE;
          end else begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
        default: begin
          state_r <= OP_IDLE;
        end
      endcase
    end
  end

  // interrupt status and mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= stat_nxt;
      if (wr_fire && wr_hit_mask) begin
        irq_mask_r <= w_lo[IRQ_W-1:0];
      end
      irq <= |(stat_nxt & irq_mask_r);
    end
  end

  flash_array u_array (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .rd_addr   (raddr_r),
    .rd_data   (mem_q),
    .wr_en     (op_done && (state_r == OP_PROG)),
    .wr_dw     (op_dw_r),
    .wr_addr   (op_dw_r ? (paddr_r & ~ARR_AW'(1)) : paddr_r),
    .wr_lo     (plo_r),
    .wr_hi     (phi_r),
    .erase_en  (op_done && (state_r == OP_ERASE)),
    .erase_blk (fcr_r[FCR_BLK_LO +: BLK_W])
  );

  // cycles spent in the current pulse, read only by the checks
  logic [CNT_W-1:0] help_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || !busy) begin
      help_cnt_r <= CNT_W'(1);
    end else begin
      help_cnt_r <= help_cnt_r + CNT_W'(1);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_LOCKED_HIDDEN: assert property (
    (wr_fire && wr_hit_fcr && !unlocked_r) |=> (fcr_r == $past(fcr_r)))
    else $error("control register changed while locked");
  AST_SETUP_NO_START: assert property (
    (fcr_wr && !busy) |=> (state_r == OP_IDLE))
    else $error("loading control register started an operation");
  AST_START_NEEDS_FWE: assert property (
    (state_r == OP_IDLE ##1 state_r == OP_PROG) |-> $past(fcr_r[FCR_FWE]))
    else $error("programming began without write enable");
  AST_MODE_NEEDS_FWMSET: assert property (
    $rose(prog_mode_r) |-> $past(fcr_wr && w_lo[FCR_FWMSET]))
    else $error("program mode entered without confirmation bit");
  AST_DEFAULT_PULSE: assert property (
    (op_done && (op_sel_r == 2'b00)) |-> (help_cnt_r == PROG_PULSE_CYC))
    else $error("default pulse has wrong length");
  AST_PULSE_COUNT: assert property (
    op_done |-> (help_cnt_r == op_len_r))
    else $error("pulse length differs from selected count");
  AST_BUSY_ENDS: assert property (
    $fell(busy) |-> $past(op_done || op_abort))
    else $error("busy fell without end of operation");
  AST_DW_FIRST_WAITS: assert property (
    dw_first |=> (!busy && half_r) ##1 !busy)
    else $error("even word alone started a double-word program");
  AST_ABORT_STOPS: assert property (
    op_abort |=> (state_r == OP_IDLE) && !prog_mode_r && !unlocked_r)
    else $error("clearing write enable did not stop activity");
  AST_SUPPLY_FAIL: assert property (
    fail_set |=> supply_fail_r)
    else $error("supply fail not flagged");

endmodule
`default_nettype wire

//--- sim/flash_program_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module flash_program_control_bench;
  import flash_pkg::*;
  localparam logic [CNT_W-1:0] E_CYC = 20'h0_0028;
  localparam logic [CNT_W-1:0] L_CYC = 20'h0_003c;
  localparam int               NP    = int'(PROG_PULSE_CYC);
  localparam logic [7:0]       PM    = 8'h21;
  localparam logic [7:0]       DW    = 8'h31;
  localparam logic [7:0]       ER    = 8'h2b;

  logic              aclk;
  logic              aresetn;
  logic [AXI_AW-1:0] awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic [AXI_AW-1:0] araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              vpp_level;
  logic              irq;
  int                errors;
  int                tests_run;
  logic [1:0]        bq[$];
  logic [33:0]       rq[$];

  // responses are always accepted at once
  flash_program_control #(.ERASE_CYC(E_CYC), .LONG_CYC(L_CYC)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(1'b1), .vpp_level(vpp_level), .irq(irq)
  );

  function automatic logic [1:0] rsp(input logic [7:0] a);
    rsp = (a > OFS_IRQ_MASK || a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
  endfunction

  function automatic logic [31:0] fx(input logic [7:0] v, input logic [2:0] s);
    fx = 32'h0000_0000;
    fx[7:0] = v;
    fx[FCR_SUPPLY_OK] = s[2];
    fx[FCR_FAIL] = s[1];
    fx[FCR_BUSY] = s[0];
  endfunction

  task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t bresp got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_r(input logic [33:0] g, input logic [33:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t read got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_v(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t irq got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bq.push_back(rsp(a));
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 500);
    if (n >= 500) errors++;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    rq.push_back({rsp(a), (rsp(a) == RESP_OKAY) ? e : 32'h0000_0000});
    araddr  <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 500);
    if (n >= 500) errors++;
  endtask

  task automatic rf(input logic [7:0] v, input logic [2:0] s);
    rd(OFS_FCR, fx(v, s));
  endtask

  task automatic ck(input logic [5:0] a, input logic [15:0] e);
    wr(OFS_RADDR, 32'(a));
    cyc(3);
    rd(OFS_RDATA, {16'h0000, e});
  endtask

  task automatic unlock();
    wr(OFS_UNLOCK, 32'(UNLOCK_KEY_A));
    wr(OFS_UNLOCK, 32'(UNLOCK_KEY_B));
  endtask

  task automatic fin(input int t);
    $display("test %0d done, errors %0d", t, errors);
  endtask

  task automatic conclude();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // the monitor sees values as sampled at the handshake edge
  always @(posedge aclk) begin
    if (aresetn && bvalid) begin
      if (bq.size() == 0) errors++;
      else cmp_b(bresp, bq.pop_front());
    end
    if (aresetn && rvalid) begin
      if (rq.size() == 0) errors++;
      else cmp_r({rresp, rdata}, rq.pop_front());
    end
  end

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    conclude();
  end

  initial begin : main
    logic [15:0] d1;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] d3;
    errors = 0;
    tests_run = 0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wvalid = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    vpp_level = 1'b1;
    void'($urandom(32'hc0de));
    d1 = 16'($urandom);
    lo = 16'($urandom);
    hi = 16'($urandom);
    d3 = 16'($urandom);
    cyc(2);
    aresetn <= 1'b1;
    cyc(2);
    rd(OFS_FCR, 32'h0000_0000);
    wr(OFS_FCR, 32'(PM));
    rd(OFS_FCR, 32'h0000_0000);
    wr(8'h40, 32'h0000_1234);
    rd(8'h40, 32'h0000_0000);
    fin(1);
    unlock();
    rd(OFS_UNLOCK, 32'h0000_0001);
    wr(OFS_FCR, 32'h0000_0001);
    wr(OFS_PADDR, 32'h0000_0014);
    wr(OFS_PDATA, 32'h0000_0000);
    cyc(5);
    rf(8'h01, 3'b000);
    wr(OFS_FCR, 32'(PM));
    vpp_level <= 1'b0;
    cyc(200);
    rf(PM, 3'b000);
    vpp_level <= 1'b1;
    cyc(4);
    rf(PM, 3'b100);
    fin(2);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    wr(OFS_PADDR, 32'h0000_0021);
    wr(OFS_PDATA, 32'(d1));
    cyc(NP - 10);
    rf(PM, 3'b101);
    cyc(12);
    rf(PM, 3'b100);
    cmp_v(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    cyc(2);
    cmp_v(irq, 1'b1);
    rd(OFS_IRQ_STAT, 32'h0000_0001);
    cyc(2);
    cmp_v(irq, 1'b0);
    rd(OFS_IRQ_STAT, 32'h0000_0000);
    fin(3);
    wr(OFS_FCR, 32'(DW));
    wr(OFS_PADDR, 32'h0000_0005);
    wr(OFS_PDATA, 32'(lo));
    cyc(5);
    rf(DW, 3'b100);
    wr(OFS_PDATA, 32'(hi));
    cyc(5);
    rf(DW, 3'b101);
    cyc(NP);
    rf(DW, 3'b100);
    rd(OFS_IRQ_STAT, 32'h0000_0001);
    fin(4);
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    wr(OFS_FCR, 32'(PM));
    wr(OFS_PADDR, 32'h0000_000a);
    wr(OFS_PDATA, 32'(d3));
    cyc(5);
    vpp_level <= 1'b0;
    cyc(NP);
    rf(PM, 3'b010);
    vpp_level <= 1'b1;
    cyc(4);
    rf(PM, 3'b110);
    cmp_v(irq, 1'b1);
    rd(OFS_IRQ_STAT, 32'h0000_0003);
    wr(OFS_FCR, 32'(PM));
    rf(PM, 3'b100);
    fin(5);
    wr(OFS_PADDR, 32'h0000_0014);
    wr(OFS_PDATA, 32'(lo));
    cyc(10);
    wr(OFS_FCR, 32'h0000_0000);
    cyc(3);
    rf(8'h00, 3'b000);
    ck(6'h14, ERASED_WORD);
    ck(6'h21, d1);
    ck(6'h04, lo);
    ck(6'h05, hi);
    ck(6'h0a, d3);
    fin(6);
    unlock();
    wr(OFS_FCR, 32'(PM));
    for (int i = 0; i < 16; i++) begin
      wr(OFS_PADDR, 32'(i));
      wr(OFS_PDATA, 32'h0000_0000);
      cyc(NP + 4);
    end
    wr(OFS_FCR, 32'(ER));
    wr(OFS_ERASE, 32'(ERASE_KEY));
    cyc(5);
    rf(ER, 3'b101);
    cyc(int'(E_CYC) + 5);
    rf(ER, 3'b100);
    wr(OFS_FCR, 32'h0000_0000);
    cyc(3);
    ck(6'h00, ERASED_WORD);
    ck(6'h0a, ERASED_WORD);
    ck(6'h0f, ERASED_WORD);
    ck(6'h21, d1);
    fin(7);
    conclude();
  end
endmodule
`default_nettype wire
